//--- acq_trig_pkg.sv
`default_nettype none
package acq_trig_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned AUTO_MIN_MS = 100;
	localparam int unsigned AUTO_MAX_MS = 500;
	localparam int unsigned AUTO_MIN_CYC = AUTO_MIN_MS * (CLK_HZ / 1000);
	localparam int unsigned AUTO_MAX_CYC = AUTO_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned SPAN_STEPS = 7;

	// Trace geometry
	localparam int TRACE_POINTS = 126;
	localparam int POINT_W = 16;
	localparam int PTR_W = 7;
	localparam logic [6:0] TRACE_LAST = 7'h7d;
	localparam logic [6:0] TRACE_END = 7'h7e;

	// Statistical terminal count
	localparam logic [31:0] TERM_MIN = 32'h00000001;
	localparam logic [31:0] TERM_MAX = 32'hee6b2800;
	localparam logic [31:0] TERM_RESET = 32'h000003e8;

	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_SOURCE = 8'h04;
	localparam logic [7:0] OFS_TERM = 8'h08;
	localparam logic [7:0] OFS_HALVE = 8'h0c;
	localparam logic [7:0] OFS_COMMAND = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_POPULATION = 8'h18;
	localparam logic [7:0] OFS_TRACE_POS = 8'h1c;
	localparam logic [7:0] OFS_TRACE_DATA = 8'h20;
	localparam logic [7:0] OFS_TRACE_CHAN = 8'h24;

	// Field positions
	localparam int MODE_LSB = 0;
	localparam int CONT_BIT = 2;
	localparam int SPAN_LSB = 4;
	localparam int TMODE_LSB = 8;
	localparam int SRC_LSB = 0;
	localparam int FALL_BIT = 4;
	localparam int CMD_BUS_BIT = 0;
	localparam int CMD_INIT_BIT = 1;
	localparam int CMD_ABORT_BIT = 2;
	localparam int ST_SWEEP_LSB = 0;
	localparam int ST_ACQ_BIT = 2;
	localparam int ST_REJ_BIT = 3;
	localparam int ST_DONE_BIT = 4;
	localparam int POS_IDX_LSB = 0;
	localparam int POS_CNT_LSB = 8;

	// Measurement modes
	localparam logic [1:0] MEAS_CW = 2'h0;
	localparam logic [1:0] MEAS_PULSE = 2'h1;
	localparam logic [1:0] MEAS_STAT = 2'h2;

	// Trigger modes
	localparam logic [1:0] TMODE_EDGE_ONLY = 2'h0;
	localparam logic [1:0] TMODE_AUTO = 2'h1;
	localparam logic [1:0] TMODE_PEAK = 2'h2;

	// Trigger sources
	localparam logic [2:0] SRC_IMMEDIATE = 3'h0;
	localparam logic [2:0] SRC_FIRST_PROBE_ORIGIN = 3'h1;
	localparam logic [2:0] SRC_SECOND_PROBE_ORIGIN = 3'h2;
	localparam logic [2:0] SRC_REAR_INPUT = 3'h3;
	localparam logic [2:0] SRC_HOST_BUS = 3'h4;
	localparam logic [2:0] SRC_HOST_ARMED_FIRST_PROBE = 3'h5;
	localparam logic [2:0] SRC_HOST_ARMED_SECOND_PROBE = 3'h6;
	localparam logic [2:0] SRC_HOST_ARMED_REAR_INPUT = 3'h7;

	typedef enum logic [1:0] {SW_IDLE, SW_ARM, SW_WAIT, SW_SWEEP} sweep_t;

endpackage
`default_nettype wire

//--- trace_store.sv
`timescale 1ns/100ps
`default_nettype none
module trace_store import acq_trig_pkg::*; #(
	parameter int DEPTH = TRACE_POINTS,
	parameter int WIDTH = POINT_W
) (
	// Clock
	input wire logic clk_sys,
	// Write side, both channels at once
	input wire logic wrEn,
	input wire logic [PTR_W-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrFirst,
	input wire logic [WIDTH-1:0] wrSecond,
	// Read side
	input wire logic rdChan,
	input wire logic [PTR_W-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] firstMem [DEPTH];
	logic [WIDTH-1:0] secondMem [DEPTH];

	// No reset: trace contents are only meaningful after a sweep
	always_ff @(posedge clk_sys) begin
		if (wrEn) begin
			firstMem[wrAddr] <= wrFirst;
			secondMem[wrAddr] <= wrSecond;
		end
	end

	always_comb begin
		rdData = '0;
		if (rdAddr < PTR_W'(DEPTH)) begin
			rdData = rdChan ? secondMem[rdAddr] : firstMem[rdAddr];
		end
	end

endmodule
`default_nettype wire

//--- acq_trig_ctrl.sv
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Rising slope: trigger when the signal rises through the level.
// - Falling slope: trigger when the signal falls through the level.
// - Probe sources take edges from the chosen first or second probe.
// - Rear source takes edges from the rear trigger input.
// - Immediate source starts a sweep at once when armed.
// - Host bus source starts one sweep per host trigger event.
// - Host-armed sources: host trigger arms, next edge starts sweep.
// - Electrical sources only accepted in pulse mode.
// - Statistical mode counts samples to a terminal count, 1 to 4000M.
// - Terminal count without continuous run stops acquisition.
// - Continuous, no halving: clear histogram and restart from zero.
// - Continuous with halving: halve populations, keep accumulating.
// - Each channel trace holds 126 points, read whole or in parts.
// - Edge-only mode on probe or rear sources sweeps only on level crossings in slope direction.
// - Auto mode forces a sweep after 100 to 500 ms without edges.
module acq_trig_ctrl import acq_trig_pkg::*; #(
	parameter int unsigned AUTO_MIN_CYCLES = AUTO_MIN_CYC,
	parameter int unsigned AUTO_MAX_CYCLES = AUTO_MAX_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Trigger comparators and host trigger message
	input wire logic firstProbeAbove,
	input wire logic secondProbeAbove,
	input wire logic rearAbove,
	input wire logic hostGet,
	// Sweep point stream
	input wire logic pointStrobe,
	input wire logic [POINT_W-1:0] firstProbePower,
	input wire logic [POINT_W-1:0] secondProbePower,
	// Statistical samples
	input wire logic sampleStrobe,
	// Acquisition control outputs
	output logic sweepActive,
	output logic sweepStart,
	output logic statAcquire,
	output logic histClear,
	output logic histHalve,
	output logic distComplete
);

	typedef struct packed {
		logic [1:0] mode;
		logic contEn;
		logic [2:0] span;
		logic [1:0] tmode;
		logic [2:0] src;
		logic falling;
		logic [31:0] termCount;
		logic halveEn;
		logic [6:0] trIndex;
		logic [6:0] trCount;
		logic [6:0] trPos;
		logic trChan;
		sweep_t sw;
		logic [6:0] pt;
		logic [31:0] autoCnt;
		logic acqRun;
		logic [31:0] pop;
		logic rejected;
		logic doneFlag;
		logic firstPrev;
		logic secondPrev;
		logic rearPrev;
		logic dWrite;
		logic [31:0] dAddr;
		logic [31:0] rdata;
		logic startPulse;
		logic clrPulse;
		logic halvePulse;
		logic donePulse;
	} ctrl_t;

	ctrl_t stateReg, stateNext;

	logic addrPhase, busTrig, cmdInit, cmdAbort, edgeHit, fire, quiet;
	logic [7:0] trAddrWide;
	logic [POINT_W-1:0] trWord;
	logic [31:0] popInc;

	function automatic logic edgeSeen(input logic cur, input logic prev,
		input logic falling);
		return falling ? (!cur && prev) : (cur && !prev);
	endfunction

	function automatic logic isElectrical(input logic [2:0] src);
		return (src != SRC_IMMEDIATE) && (src != SRC_HOST_BUS);
	endfunction

	function automatic logic isHostArmed(input logic [2:0] src);
		return src >= SRC_HOST_ARMED_FIRST_PROBE;
	endfunction

	// Longer timespans wait longer before forcing a trace
	function automatic logic [31:0] autoLimit(input logic [2:0] span);
		logic [31:0] step;
		step = 32'((AUTO_MAX_CYCLES - AUTO_MIN_CYCLES) / SPAN_STEPS);
		return 32'(AUTO_MIN_CYCLES) + 32'(step * {29'h0, span});
	endfunction

	assign trAddrWide = {1'b0, stateReg.trIndex} + {1'b0, stateReg.trPos};
	assign addrPhase = hsel && htrans[1] && hready;
	assign quiet = !stateReg.dWrite;
	assign popInc = stateReg.pop + 32'h1;

	trace_store #(
		.DEPTH(TRACE_POINTS),
		.WIDTH(POINT_W)
	) trace_store_i (
		.clk_sys(clk_sys),
		.wrEn(stateReg.sw == SW_SWEEP && pointStrobe),
		.wrAddr(stateReg.pt),
		.wrFirst(firstProbePower),
		.wrSecond(secondProbePower),
		.rdChan(stateReg.trChan),
		.rdAddr(trAddrWide[6:0]),
		.rdData(trWord)
	);

	always_comb begin
		stateNext = stateReg;
		stateNext.startPulse = 1'b0;
		stateNext.clrPulse = 1'b0;
		stateNext.halvePulse = 1'b0;
		stateNext.donePulse = 1'b0;
		stateNext.firstPrev = firstProbeAbove;
		stateNext.secondPrev = secondProbeAbove;
		stateNext.rearPrev = rearAbove;
		busTrig = hostGet;
		cmdInit = 1'b0;
		cmdAbort = 1'b0;
		fire = 1'b0;

		// Low source bits pick the input for direct and host-armed forms
		case (stateReg.src[1:0])
			2'h1: edgeHit = edgeSeen(firstProbeAbove, stateReg.firstPrev,
				stateReg.falling);
			2'h2: edgeHit = edgeSeen(secondProbeAbove, stateReg.secondPrev,
				stateReg.falling);
			2'h3: edgeHit = edgeSeen(rearAbove, stateReg.rearPrev,
				stateReg.falling);
			default: edgeHit = 1'b0;
		endcase

		// Write data phase; a rejected setting leaves the old value
		if (stateReg.dWrite) begin
			if (stateReg.dAddr == {24'h0, OFS_STATUS}) begin
				if (hwdata[ST_REJ_BIT]) begin
					stateNext.rejected = 1'b0;
				end
				if (hwdata[ST_DONE_BIT]) begin
					stateNext.doneFlag = 1'b0;
				end
			end else if (stateReg.dAddr == {24'h0, OFS_MODE}) begin
				if (hwdata[MODE_LSB+:2] == 2'h3 || hwdata[TMODE_LSB+:2] == 2'h3)
				begin
					stateNext.rejected = 1'b1;
				end else begin
					stateNext.mode = hwdata[MODE_LSB+:2];
					stateNext.contEn = hwdata[CONT_BIT];
					stateNext.span = hwdata[SPAN_LSB+:3];
					stateNext.tmode = hwdata[TMODE_LSB+:2];
				end
				if (stateNext.mode != MEAS_PULSE && isElectrical(stateReg.src))
				begin
					stateNext.src = SRC_IMMEDIATE;
				end
			end else if (stateReg.dAddr == {24'h0, OFS_SOURCE}) begin
				if (isElectrical(hwdata[SRC_LSB+:3]) &&
					stateReg.mode != MEAS_PULSE) begin
					stateNext.rejected = 1'b1;
				end else begin
					stateNext.src = hwdata[SRC_LSB+:3];
				end
				if (stateReg.mode == MEAS_PULSE) begin
					stateNext.falling = hwdata[FALL_BIT];
				end else if (hwdata[FALL_BIT] != stateReg.falling) begin
					stateNext.rejected = 1'b1;
				end
			end else if (stateReg.dAddr == {24'h0, OFS_TERM}) begin
				if (stateReg.mode == MEAS_STAT && hwdata >= TERM_MIN &&
					hwdata <= TERM_MAX) begin
					stateNext.termCount = hwdata;
				end else begin
					stateNext.rejected = 1'b1;
				end
			end else if (stateReg.dAddr == {24'h0, OFS_HALVE}) begin
				if (stateReg.mode == MEAS_STAT) begin
					stateNext.halveEn = hwdata[0];
				end else begin
					stateNext.rejected = 1'b1;
				end
			end else if (stateReg.dAddr == {24'h0, OFS_COMMAND}) begin
				busTrig = hostGet || hwdata[CMD_BUS_BIT];
				cmdInit = hwdata[CMD_INIT_BIT];
				cmdAbort = hwdata[CMD_ABORT_BIT];
			end else if (stateReg.dAddr == {24'h0, OFS_TRACE_POS}) begin
				if (hwdata[POS_IDX_LSB+:7] > TRACE_LAST ||
					hwdata[POS_CNT_LSB+:7] > TRACE_END) begin
					stateNext.rejected = 1'b1;
				end else begin
					stateNext.trIndex = hwdata[POS_IDX_LSB+:7];
					stateNext.trCount = hwdata[POS_CNT_LSB+:7];
					stateNext.trPos = 7'h0;
				end
			end else if (stateReg.dAddr == {24'h0, OFS_TRACE_CHAN}) begin
				stateNext.trChan = hwdata[0];
			end
		end

		// Sweep sequencer; mid-sweep only point strobes, an abort or a switch to statistical mode matter
		case (stateReg.sw)
			SW_IDLE: begin
				stateNext.autoCnt = 32'h0;
				if (cmdInit || stateReg.contEn) begin
					stateNext.sw = isHostArmed(stateReg.src) ? SW_ARM : SW_WAIT;
				end
			end
			SW_ARM: begin
				if (busTrig) begin
					stateNext.sw = SW_WAIT;
				end
			end
			SW_WAIT: begin
				if (stateReg.src == SRC_IMMEDIATE) begin
					fire = 1'b1;
				end else if (stateReg.src == SRC_HOST_BUS) begin
					fire = busTrig;
				end else if (edgeHit) begin
					fire = 1'b1;
				end else if (stateReg.tmode != TMODE_EDGE_ONLY &&
					stateReg.autoCnt >= autoLimit(stateReg.span)) begin
					fire = 1'b1;
				end
				stateNext.autoCnt = stateReg.autoCnt + 32'h1;
				if (fire) begin
					stateNext.sw = SW_SWEEP;
					stateNext.pt = 7'h0;
					stateNext.startPulse = 1'b1;
					stateNext.autoCnt = 32'h0;
				end
			end
			SW_SWEEP: begin
				if (pointStrobe) begin
					stateNext.pt = stateReg.pt + 7'h1;
					if (stateReg.pt == TRACE_LAST) begin
						stateNext.pt = 7'h0;
						if (!stateReg.contEn) begin
							stateNext.sw = SW_IDLE;
						end else begin
							stateNext.sw = isHostArmed(stateReg.src) ? SW_ARM : SW_WAIT;
						end
					end
				end
			end
			default: stateNext.sw = SW_IDLE;
		endcase
		if (cmdAbort || stateNext.mode == MEAS_STAT) begin
			stateNext.sw = SW_IDLE;
		end

		// Statistical population counting
		if (cmdInit && stateNext.mode == MEAS_STAT) begin
			stateNext.acqRun = 1'b1;
		end
		if (stateReg.acqRun && sampleStrobe) begin
			stateNext.pop = popInc;
			if (popInc >= stateReg.termCount) begin
				stateNext.donePulse = 1'b1;
				stateNext.doneFlag = 1'b1;
				if (!stateReg.contEn) begin
					stateNext.acqRun = 1'b0;
				end else if (stateReg.halveEn) begin
					stateNext.pop = popInc >> 1;
					stateNext.halvePulse = 1'b1;
				end else begin
					stateNext.pop = 32'h0;
					stateNext.clrPulse = 1'b1;
				end
			end
		end
		if (cmdAbort || stateNext.mode != MEAS_STAT) begin
			stateNext.acqRun = 1'b0;
		end
		if (cmdInit && stateNext.mode == MEAS_STAT && !stateReg.acqRun) begin
			stateNext.pop = 32'h0;
		end

		// Address phase; register read data reflects this cycle's write, trace data uses the registered channel and position
		stateNext.dWrite = addrPhase && hwrite;
		stateNext.dAddr = haddr;
		if (addrPhase && !hwrite) begin
			stateNext.rdata = 32'h0;
			if (haddr == {24'h0, OFS_MODE}) begin
				stateNext.rdata[MODE_LSB+:2] = stateNext.mode;
				stateNext.rdata[CONT_BIT] = stateNext.contEn;
				stateNext.rdata[SPAN_LSB+:3] = stateNext.span;
				stateNext.rdata[TMODE_LSB+:2] = stateNext.tmode;
			end else if (haddr == {24'h0, OFS_SOURCE}) begin
				stateNext.rdata[SRC_LSB+:3] = stateNext.src;
				stateNext.rdata[FALL_BIT] = stateNext.falling;
			end else if (haddr == {24'h0, OFS_TERM}) begin
				stateNext.rdata = stateNext.termCount;
			end else if (haddr == {24'h0, OFS_HALVE}) begin
				stateNext.rdata[0] = stateNext.halveEn;
			end else if (haddr == {24'h0, OFS_STATUS}) begin
				stateNext.rdata[ST_SWEEP_LSB+:2] = stateNext.sw;
				stateNext.rdata[ST_ACQ_BIT] = stateNext.acqRun;
				stateNext.rdata[ST_REJ_BIT] = stateNext.rejected;
				stateNext.rdata[ST_DONE_BIT] = stateNext.doneFlag;
			end else if (haddr == {24'h0, OFS_POPULATION}) begin
				stateNext.rdata = stateNext.pop;
			end else if (haddr == {24'h0, OFS_TRACE_POS}) begin
				stateNext.rdata[POS_IDX_LSB+:7] = stateNext.trIndex;
				stateNext.rdata[POS_CNT_LSB+:7] = stateNext.trCount;
			end else if (haddr == {24'h0, OFS_TRACE_CHAN}) begin
				stateNext.rdata[0] = stateNext.trChan;
			end else if (haddr == {24'h0, OFS_TRACE_DATA}) begin
				// Block of trCount points; index advances when it is used up
				if (trAddrWide < 8'(TRACE_POINTS)) begin
					stateNext.rdata[POINT_W-1:0] = trWord;
				end
				if (stateReg.trCount != 7'h0) begin
					stateNext.trPos = stateReg.trPos + 7'h1;
					if (stateReg.trPos + 7'h1 == stateReg.trCount ||
						trAddrWide >= 8'(TRACE_LAST)) begin
						stateNext.trIndex = (trAddrWide >= 8'(TRACE_LAST)) ?
							TRACE_END : trAddrWide[6:0] + 7'h1;
						stateNext.trPos = 7'h0;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stateReg <= '0;
			stateReg.termCount <= TERM_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign hrdata = stateReg.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign sweepActive = stateReg.sw == SW_SWEEP;
	assign sweepStart = stateReg.startPulse;
	assign statAcquire = stateReg.acqRun;
	assign histClear = stateReg.clrPulse;
	assign histHalve = stateReg.halvePulse;
	assign distComplete = stateReg.donePulse;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	a_rise_start: assert property (
		(stateReg.sw == SW_WAIT && stateReg.src == SRC_FIRST_PROBE_ORIGIN &&
		!stateReg.falling && firstProbeAbove && !stateReg.firstPrev && quiet)
		|=> sweepStart && sweepActive) else $error("rising edge missed");
	a_fall_start: assert property (
		(stateReg.sw == SW_WAIT && stateReg.src == SRC_FIRST_PROBE_ORIGIN &&
		stateReg.falling && !firstProbeAbove && stateReg.firstPrev && quiet)
		|=> sweepStart) else $error("falling edge missed");
	a_second_probe: assert property (
		(stateReg.sw == SW_WAIT && stateReg.src == SRC_SECOND_PROBE_ORIGIN &&
		!stateReg.falling && secondProbeAbove && !stateReg.secondPrev && quiet)
		|=> sweepStart) else $error("second probe edge missed");
	a_rear_start: assert property (
		(stateReg.sw == SW_WAIT && stateReg.src == SRC_REAR_INPUT &&
		!stateReg.falling && rearAbove && !stateReg.rearPrev && quiet)
		|=> sweepStart) else $error("rear edge missed");
	a_immed_start: assert property (
		(stateReg.sw == SW_IDLE && stateReg.contEn && quiet &&
		stateReg.src == SRC_IMMEDIATE && stateReg.mode != MEAS_STAT)
		|=> ##1 sweepStart) else $error("immediate sweep late");
	a_bus_start: assert property (
		(stateReg.sw == SW_WAIT && stateReg.src == SRC_HOST_BUS && quiet)
		|=> sweepStart == $past(hostGet)) else $error("bus sweep wrong");
	a_arm_only: assert property (
		(stateReg.sw == SW_ARM && hostGet && quiet)
		|=> stateReg.sw == SW_WAIT && !sweepStart) else $error("arm fired");
	a_src_legal: assert property (
		stateReg.mode != MEAS_PULSE |-> !isElectrical(stateReg.src))
		else $error("electrical source outside pulse mode");
	a_dist_done: assert property (
		(stateReg.acqRun && sampleStrobe && popInc >= stateReg.termCount)
		|=> distComplete ##1 !distComplete) else $error("no completion");
	a_stat_stop: assert property (
		(stateReg.acqRun && sampleStrobe && popInc >= stateReg.termCount &&
		!stateReg.contEn) |=> !statAcquire && !histClear && !histHalve)
		else $error("acquisition did not stop");
	a_stat_clear: assert property (
		(stateReg.acqRun && sampleStrobe && popInc >= stateReg.termCount &&
		stateReg.contEn && !stateReg.halveEn && quiet)
		|=> histClear && stateReg.pop == 32'h0) else $error("no clear");
	a_stat_halve: assert property (
		(stateReg.acqRun && sampleStrobe && popInc >= stateReg.termCount &&
		stateReg.contEn && stateReg.halveEn && quiet)
		|=> histHalve && statAcquire &&
		stateReg.pop == ($past(stateReg.pop) + 32'h1) >> 1)
		else $error("no halving");
	a_trace_len: assert property (
		(sweepActive && pointStrobe && stateReg.pt == TRACE_LAST &&
		!stateReg.contEn && quiet) |=> !sweepActive)
		else $error("sweep length wrong");
	a_edge_only: assert property (
		(stateReg.sw == SW_WAIT && stateReg.mode == MEAS_PULSE &&
		stateReg.tmode == TMODE_EDGE_ONLY && isElectrical(stateReg.src) &&
		!edgeHit && quiet) |=> !sweepStart) else $error("sweep without edge");
	a_auto_force: assert property (
		(stateReg.sw == SW_WAIT && stateReg.tmode != TMODE_EDGE_ONLY &&
		isElectrical(stateReg.src) &&
		stateReg.autoCnt >= autoLimit(stateReg.span) && quiet)
		|=> sweepStart) else $error("auto trace not forced");
	a_busy_ignore: assert property (
		(sweepActive && hostGet && !pointStrobe && quiet)
		|=> sweepActive && !sweepStart) else $error("trigger mid-sweep");
	a_term_hold: assert property (
		stateReg.mode != MEAS_STAT
		|=> $stable(stateReg.termCount) && $stable(stateReg.halveEn))
		else $error("statistical setting changed");

endmodule
`default_nettype wire

//--- acq_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module acq_host_model (
	// Clock
	input wire logic clk_sys,
	// AHB-Lite master
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Host trigger message
	output logic hostGet
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hostGet = 1'b0;
	end
	// Each phase held until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
		q = hrdata;
		// Stale data must not look valid
		hwdata <= ~d;
	endtask
	task automatic trig();
		@(posedge clk_sys);
		hostGet <= 1'b1;
		@(posedge clk_sys);
		hostGet <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- test_acquisition_trigger_control.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin #1; checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_acquisition_trigger_control import acq_trig_pkg::*; ();
	logic clk_sys, arst_n, hsel, hwrite, hreadyout, hresp, hostGet;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic firstProbeAbove, secondProbeAbove, rearAbove;
	logic pointStrobe, sampleStrobe, sweepActive, sweepStart, statAcquire;
	logic histClear, histHalve, distComplete;
	logic [15:0] firstProbePower, secondProbePower;
	logic [15:0] q[$];
	int n_errors, checks, seed, cyc, nStart, nDone, nHalve, nClr;
	int pop, run, e, s, f, edn, ehv, ecl;
	int srcs[6] = '{1, 2, 3, 5, 6, 7};
	acq_trig_ctrl #(.AUTO_MIN_CYCLES(20), .AUTO_MAX_CYCLES(90)) acq_trig_ctrl_i (
		.clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.firstProbeAbove, .secondProbeAbove, .rearAbove, .hostGet,
		.pointStrobe, .firstProbePower, .secondProbePower, .sampleStrobe,
		.sweepActive, .sweepStart, .statAcquire, .histClear, .histHalve,
		.distComplete);
	acq_host_model acq_host_model_i (.clk_sys, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hostGet);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		nStart += (sweepStart === 1'b1);
		nDone += (distComplete === 1'b1);
		nHalve += (histHalve === 1'b1);
		nClr += (histClear === 1'b1);
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic clks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acq_host_model_i.xfer(1'b1, a, d, rd);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] x);
		acq_host_model_i.xfer(1'b0, a, 32'h0, rd);
		`CHK({rd, hresp}, {x, 1'b0})
	endtask
	task automatic pts();
		logic [15:0] v;
		q.delete();
		repeat (126) begin
			@(posedge clk_sys);
			v = 16'($random(seed));
			pointStrobe <= 1'b1;
			firstProbePower <= v;
			secondProbePower <= ~v;
			q.push_back(v);
		end
		@(posedge clk_sys);
		pointStrobe <= 1'b0;
		clks(3);
		`CHK(sweepActive, 1'b0)
	endtask
	task automatic lvl(input int n, input logic v);
		@(posedge clk_sys);
		case (n % 4)
			1: firstProbeAbove <= v;
			2: secondProbeAbove <= v;
			default: rearAbove <= v;
		endcase
		clks(2);
	endtask
	initial begin
		seed = 32'hcc7f;
		arst_n = 1'b0;
		{firstProbeAbove, secondProbeAbove, rearAbove} = 3'h0;
		{pointStrobe, sampleStrobe} = 2'h0;
		{firstProbePower, secondProbePower} = 32'h0;
		clks(8);
		arst_n <= 1'b1;
		rc(OFS_TERM, 32'h3e8);
		wr(OFS_TERM, 32'h5);
		rc(OFS_TERM, 32'h3e8);
		wr(OFS_SOURCE, 32'h1);
		rc(OFS_SOURCE, 32'h0);
		rc(OFS_STATUS, 32'h8);
		wr(OFS_STATUS, 32'h8);
		wr(8'h30, 32'h1);
		rc(8'h30, 32'h0);
		wr(OFS_SOURCE, 32'h4);
		rc(OFS_SOURCE, 32'h4);
		wr(OFS_COMMAND, 32'h2);
		acq_host_model_i.trig();
		clks(3);
		acq_host_model_i.trig();
		pts();
		`CHK(nStart, 1)
		wr(OFS_MODE, 32'h1);
		wr(OFS_SOURCE, 32'h0);
		wr(OFS_COMMAND, 32'h2);
		clks(3);
		pts();
		`CHK(nStart, 2)
		e = 2;
		for (int i = 0; i < 12; i++) begin
			s = srcs[i / 2];
			f = i % 2;
			wr(OFS_SOURCE, 32'(s | (f << 4)));
			wr(OFS_COMMAND, 32'h2);
			// Edges before arming must be ignored
			if (s > 4) begin
				lvl(s, 1'b1);
				lvl(s, 1'b0);
				acq_host_model_i.trig();
				clks(2);
			end
			lvl(s, 1'b1);
			if (f == 0) pts();
			lvl(s, 1'b0);
			if (f == 1) pts();
			e++;
			`CHK(nStart, e)
		end
		wr(OFS_TRACE_POS, 32'h0);
		clks(1);
		rc(OFS_TRACE_DATA, {16'h0, q[0]});
		// Two-point block from the second channel
		wr(OFS_TRACE_CHAN, 32'h1);
		wr(OFS_TRACE_POS, 32'h200);
		clks(1);
		rc(OFS_TRACE_DATA, {16'h0, ~q[0]});
		rc(OFS_TRACE_DATA, {16'h0, ~q[1]});
		rc(OFS_TRACE_POS, 32'h202);
		// Span step 1: forced after 30 quiet cycles
		wr(OFS_MODE, 32'h111);
		wr(OFS_SOURCE, 32'h1);
		wr(OFS_COMMAND, 32'h2);
		clks(29);
		`CHK(nStart, e)
		clks(4);
		`CHK(nStart, e + 1)
		pts();
		`CHK(nStart, e + 1)
		// Continuous immediate starts without an initiate
		wr(OFS_SOURCE, 32'h0);
		wr(OFS_MODE, 32'h5);
		clks(3);
		wr(OFS_MODE, 32'h1);
		pts();
		`CHK(nStart, e + 2)
		for (int c = 0; c < 3; c++) begin
			wr(OFS_MODE, 32'h0);
			wr(OFS_MODE, 32'(2 | ((c > 0) << 2)));
			wr(OFS_TERM, 32'h3);
			wr(OFS_HALVE, 32'(c == 2));
			wr(OFS_COMMAND, 32'h2);
			pop = 0;
			run = 1;
			repeat (4) begin
				@(posedge clk_sys);
				sampleStrobe <= 1'b1;
				@(posedge clk_sys);
				sampleStrobe <= 1'b0;
				clks(2);
				pop += run;
				if (run == 1 && pop >= 3) begin
					edn++;
					if (c == 0) run = 0;
					else if (c == 2) pop = pop >> 1;
					else pop = 0;
					ehv += (c == 2);
					ecl += (c == 1);
				end
			end
			`CHK(statAcquire, run[0])
			rc(OFS_POPULATION, 32'(pop));
			`CHK({nDone, nHalve, nClr}, {edn, ehv, ecl})
		end
		wr(OFS_COMMAND, 32'h4);
		`CHK(statAcquire, 1'b0)
		end_of_test();
	end
endmodule
`default_nettype wire
